// ---- dv/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.vh"

// ----------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------
module testbench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic debug_mode = 1'b0;
  logic ce = 1'b1;
  wire [11:0] awaddr, araddr;
  wire [31:0] wdata, rdata;
  wire [3:0] wstrb;
  wire [1:0] bresp, rresp;
  wire awvalid, awready, wvalid, wready, bvalid, bready;
  wire arvalid, arready, rvalid, rready, nmi, sys_rst, irq;
  int err_count = 0;
  int checks = 0;
  int n;
  logic [31:0] v, c0;

  // Clock enable is driven so that one scenario can show that it freezes the count.
  wdt_top wdt_top_i (.CLK_IN(clk), .ARST_N_IN(arst_n), .CE_IN(ce),
    .DEBUG_MODE_IN(debug_mode), .AWADDR_IN(awaddr), .AWVALID_IN(awvalid),
    .AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid),
    .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
    .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready), .RDATA_OUT(rdata),
    .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready),
    .TIMEOUT_NMI_REQUEST_OUT(nmi), .WATCHDOG_SYSTEM_RESET_OUT(sys_rst), .IRQ_OUT(irq));

  wdt_cpu_model wdt_cpu_model_i (.clk_in(clk), .awaddr_out(awaddr), .awvalid_out(awvalid),
    .awready_in(awready), .wdata_out(wdata), .wstrb_out(wstrb), .wvalid_out(wvalid),
    .wready_in(wready), .bresp_in(bresp), .bvalid_in(bvalid), .bready_out(bready),
    .araddr_out(araddr), .arvalid_out(arvalid), .arready_in(arready), .rdata_in(rdata),
    .rresp_in(rresp), .rvalid_in(rvalid), .rready_out(rready));

  // 200 MHz clock.
  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict(input bit hung);
    if (hung) err_count++;
    if (err_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    wdt_cpu_model_i.rd(a);
    d = wdt_cpu_model_i.data;
  endtask

  // Counts whole clock cycles, sampled at each falling edge, until the chosen output goes high, with a bound.
  task automatic wait_out(input bit want_rst, output int cnt);
    cnt = 0;
    while ((want_rst ? sys_rst : nmi) !== 1'b1) begin
      @(negedge clk);
      cnt++;
      if (cnt > 20000) give_verdict(1'b1);
    end
  endtask

  // Main sequence.
  initial begin
    do_reset();
    // Missed service: overflow, interrupt, prewarning, reset.
    rd(`WDT_CTRL_OFS, v);
    check(v, 32'h0);
    rd(12'hffc, v);
    check(v, 32'h0);
    check(wdt_cpu_model_i.resp, `WDT_RESP_SLVERR);
    wdt_cpu_model_i.wr(`WDT_RELOAD_OFS, 32'hff);
    wdt_cpu_model_i.wr(`WDT_MASK_OFS, 32'h7);
    wdt_cpu_model_i.wr(`WDT_CTRL_OFS, 32'h1);
    wdt_cpu_model_i.wr(`WDT_SERVICE_OFS, `WDT_SERVICE_KEY);
    rd(`WDT_COUNT_OFS, v);
    check(v[17:8], 10'h1ff);
    check(v[7:0] < 8'h08, 1'b1);
    wait_out(1'b0, n);
    check(n >= 470 && n <= 515, 1'b1);
    check(sys_rst, 1'b0);
    wait_out(1'b1, n);
    check(n >= 90 && n <= 100, 1'b1);
    wdt_cpu_model_i.lag = 3;
    rd(`WDT_STATUS_OFS, v);
    check(v[2:0], 3'b101);
    check(irq, 1'b1);
    wdt_cpu_model_i.wr(`WDT_MASK_OFS, 32'h0);
    check(irq, 1'b0);
    wdt_cpu_model_i.wr(`WDT_MASK_OFS, 32'h7);
    wdt_cpu_model_i.wr(`WDT_STATUS_OFS, 32'h7);
    rd(`WDT_STATUS_OFS, v);
    check(v, 32'h0);
    check(irq, 1'b0);
    wdt_cpu_model_i.wr(12'hffc, 32'h0);
    check(wdt_cpu_model_i.resp, `WDT_RESP_SLVERR);
    wdt_cpu_model_i.lag = 0;
    // Window check: service just past the boundary is good, inside it is not.
    do_reset();
    wdt_cpu_model_i.wr(`WDT_CTRL_OFS, 32'h5);
    rd(`WDT_COUNT_OFS, v);
    wdt_cpu_model_i.wr(`WDT_SERVICE_OFS, `WDT_SERVICE_KEY);
    rd(`WDT_COUNT_OFS, v);
    check(v[17:16], 2'd1);
    wdt_cpu_model_i.wr(`WDT_WINDOW_OFS, 32'h80);
    wdt_cpu_model_i.wr(`WDT_SERVICE_OFS, `WDT_SERVICE_KEY);
    rd(`WDT_COUNT_OFS, v);
    check(v[17:16], 2'd2);
    rd(`WDT_STATUS_OFS, v);
    check(v[2:0], 3'b010);
    wait_out(1'b1, n);
    check(n <= 100, 1'b1);
    check(nmi, 1'b0);
    // Slow prescale, then suspension in debug mode.
    do_reset();
    wdt_cpu_model_i.wr(`WDT_CTRL_OFS, 32'h3);
    rd(`WDT_COUNT_OFS, c0);
    repeat (1280) @(posedge clk);
    rd(`WDT_COUNT_OFS, v);
    check(v[15:0] - c0[15:0] >= 9 && v[15:0] - c0[15:0] <= 11, 1'b1);
    debug_mode <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`WDT_COUNT_OFS, c0);
    repeat (1280) @(posedge clk);
    rd(`WDT_COUNT_OFS, v);
    check(v[15:0], c0[15:0]);
    // Software lets the count run on through debug mode.
    wdt_cpu_model_i.wr(`WDT_CTRL_OFS, 32'hb);
    rd(`WDT_COUNT_OFS, c0);
    repeat (1280) @(posedge clk);
    rd(`WDT_COUNT_OFS, v);
    check(v[15:0] - c0[15:0] >= 9 && v[15:0] - c0[15:0] <= 11, 1'b1);
    debug_mode <= 1'b0;
    // Clock enable low freezes the count; only the read cycles may add a tick.
    rd(`WDT_COUNT_OFS, c0);
    ce <= 1'b0;
    repeat (1280) @(posedge clk);
    ce <= 1'b1;
    rd(`WDT_COUNT_OFS, v);
    check(v[15:0] - c0[15:0] <= 1, 1'b1);
    give_verdict(1'b0);
  end
endmodule
`default_nettype wire

// ---- dv/wdt_checker_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Port-level checks of the watchdog and its register bus
// ----------------------------------------------------------------
module wdt_checker (
  // Clock and reset.
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic CE_IN,
  // Bus handshakes.
  input wire logic AWREADY_OUT,
  input wire logic WREADY_OUT,
  input wire logic [1:0] BRESP_OUT,
  input wire logic BVALID_OUT,
  input wire logic BREADY_IN,
  input wire logic ARVALID_IN,
  input wire logic ARREADY_OUT,
  input wire logic [31:0] RDATA_OUT,
  input wire logic [1:0] RRESP_OUT,
  input wire logic RVALID_OUT,
  input wire logic RREADY_IN,
  // Watchdog outputs.
  input wire logic TIMEOUT_NMI_REQUEST_OUT,
  input wire logic WATCHDOG_SYSTEM_RESET_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!ARST_N_IN);

  logic [15:0] gap;

  // Cycles since the timeout request rose; saturates so a stuck run never wraps.
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      gap <= 16'h0;
    end else if (!TIMEOUT_NMI_REQUEST_OUT) begin
      gap <= 16'h0;
    end else if (gap != 16'hffff) begin
      gap <= gap + 16'h1;
    end
  end

  a_nmi_sticky: assert property (TIMEOUT_NMI_REQUEST_OUT |=> TIMEOUT_NMI_REQUEST_OUT)
    else $error("timeout request dropped");
  a_reset_sticky: assert property (WATCHDOG_SYSTEM_RESET_OUT |=> WATCHDOG_SYSTEM_RESET_OUT)
    else $error("system reset dropped");
  a_nmi_first: assert property ($rose(TIMEOUT_NMI_REQUEST_OUT) |-> !WATCHDOG_SYSTEM_RESET_OUT)
    else $error("reset came with the timeout request");
  a_prewarn_length: assert property ($rose(WATCHDOG_SYSTEM_RESET_OUT) && TIMEOUT_NMI_REQUEST_OUT
    |-> gap >= 16'd90 && gap <= 16'd6200)
    else $error("prewarning length wrong");
  a_read_answer: assert property (ARVALID_IN && ARREADY_OUT && CE_IN |=> RVALID_OUT)
    else $error("read answer late");
  a_read_hold: assert property (RVALID_OUT && !RREADY_IN
    |=> RVALID_OUT && $stable(RDATA_OUT) && $stable(RRESP_OUT))
    else $error("read answer not held");
  a_write_hold: assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
    else $error("write answer not held");
  a_write_busy: assert property (BVALID_OUT |-> !AWREADY_OUT && !WREADY_OUT)
    else $error("write taken while answer waits");
  a_read_busy: assert property (RVALID_OUT |-> !ARREADY_OUT)
    else $error("read taken while answer waits");

  c_nmi: cover property ($rose(TIMEOUT_NMI_REQUEST_OUT));
  c_reset: cover property ($rose(WATCHDOG_SYSTEM_RESET_OUT));
  c_slow_read: cover property (RVALID_OUT && !RREADY_IN);
endmodule

bind wdt_top wdt_checker wdt_checker_i (.CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN), .CE_IN(CE_IN),
  .AWREADY_OUT(AWREADY_OUT), .WREADY_OUT(WREADY_OUT), .BRESP_OUT(BRESP_OUT),
  .BVALID_OUT(BVALID_OUT), .BREADY_IN(BREADY_IN), .ARVALID_IN(ARVALID_IN),
  .ARREADY_OUT(ARREADY_OUT), .RDATA_OUT(RDATA_OUT), .RRESP_OUT(RRESP_OUT),
  .RVALID_OUT(RVALID_OUT), .RREADY_IN(RREADY_IN),
  .TIMEOUT_NMI_REQUEST_OUT(TIMEOUT_NMI_REQUEST_OUT),
  .WATCHDOG_SYSTEM_RESET_OUT(WATCHDOG_SYSTEM_RESET_OUT));
`default_nettype wire

// ---- dv/wdt_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Processor side: a bus master issuing one access at a time
// ----------------------------------------------------------------
module wdt_cpu_model (
  // Clock.
  input wire logic clk_in,
  // Write side.
  output logic [11:0] awaddr_out,
  output logic awvalid_out,
  input wire logic awready_in,
  output logic [31:0] wdata_out,
  output logic [3:0] wstrb_out,
  output logic wvalid_out,
  input wire logic wready_in,
  input wire logic [1:0] bresp_in,
  input wire logic bvalid_in,
  output logic bready_out,
  // Read side.
  output logic [11:0] araddr_out,
  output logic arvalid_out,
  input wire logic arready_in,
  input wire logic [31:0] rdata_in,
  input wire logic [1:0] rresp_in,
  input wire logic rvalid_in,
  output logic rready_out
);
  int lag = 0; // Cycles the response ready is held back, to act as a slow processor.
  logic [1:0] resp;
  logic [31:0] data;

  // Idle bus at time zero.
  initial begin
    {awaddr_out, awvalid_out, wdata_out, wstrb_out, wvalid_out, bready_out} = '0;
    {araddr_out, arvalid_out, rready_out} = '0;
  end

  // One write; handshakes are sampled late in the cycle so a ready that
  // changes at the edge itself is never misread.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    logic ha, hw, hb;
    hb = 1'b0;
    @(posedge clk_in);
    awaddr_out <= a;
    awvalid_out <= 1'b1;
    wdata_out <= d;
    wstrb_out <= 4'h1;
    wvalid_out <= 1'b1;
    for (n = 0; n < 200 && !hb; n++) begin
      @(negedge clk_in);
      ha = awvalid_out && awready_in;
      hw = wvalid_out && wready_in;
      hb = bready_out && bvalid_in;
      resp = bresp_in;
      @(posedge clk_in);
      if (ha) awvalid_out <= 1'b0;
      if (hw) wvalid_out <= 1'b0;
      bready_out <= !hb && n >= lag;
    end
    if (!hb) testbench.give_verdict(1'b1);
  endtask

  // One read; data and response are sampled at the falling edge before the accepting edge.
  task automatic rd(input logic [11:0] a);
    int n;
    logic ha, hr;
    hr = 1'b0;
    @(posedge clk_in);
    araddr_out <= a;
    arvalid_out <= 1'b1;
    for (n = 0; n < 200 && !hr; n++) begin
      @(negedge clk_in);
      ha = arvalid_out && arready_in;
      hr = rready_out && rvalid_in;
      resp = rresp_in;
      data = rdata_in;
      @(posedge clk_in);
      if (ha) arvalid_out <= 1'b0;
      rready_out <= !hr && n >= lag;
    end
    if (!hr) testbench.give_verdict(1'b1);
  endtask
endmodule
`default_nettype wire

// ---- rtl/wdt_counter.v ----
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.vh"

// Two cascaded byte stages forming the 16-bit watchdog count.
module wdt_counter (
  // Clock and reset.
  input wire clk_in,
  input wire arst_n_in,
  // Control.
  input wire tick_in,
  input wire load_in,
  input wire [7:0] reload_in,
  // State.
  output reg [15:0] count_out,
  output wire ovf_out
);

  wire low_carry = (count_out[7:0] == 8'hff);

  assign ovf_out = tick_in && (count_out == 16'hffff);

  // Service loads high byte and clears low byte; a tick beside it is dropped.
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count_out <= 16'h0000;
    end else if (load_in) begin
      count_out <= {reload_in, 8'h00};
    end else if (tick_in) begin
      count_out[7:0] <= count_out[7:0] + 8'h01;
      if (low_carry) begin
        count_out[15:8] <= count_out[15:8] + 8'h01;
      end
    end
  end

endmodule
`default_nettype wire

// ---- rtl/wdt_map.vh ----
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

// ---------------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------------
`define WDT_CTRL_OFS 12'h000
`define WDT_RELOAD_OFS 12'h004
`define WDT_WINDOW_OFS 12'h008
`define WDT_SERVICE_OFS 12'h00c
`define WDT_COUNT_OFS 12'h010
`define WDT_STATUS_OFS 12'h014
`define WDT_MASK_OFS 12'h018

// ---------------------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------------------
`define WDT_CTRL_EN_BIT 0
`define WDT_CTRL_PRESCALE_BIT 1
`define WDT_CTRL_WINEN_BIT 2
`define WDT_CTRL_DBGRUN_BIT 3
`define WDT_CTRL_RST 4'h0

// ---------------------------------------------------------------------------
// Status and mask fields
// ---------------------------------------------------------------------------
`define WDT_ST_TIMEOUT_BIT 0
`define WDT_ST_BADREF_BIT 1
`define WDT_ST_RESET_BIT 2
`define WDT_ST_WIDTH 3

// ---------------------------------------------------------------------------
// Reset values, timing counts, service key and bus responses
// ---------------------------------------------------------------------------
`define WDT_RELOAD_RST 8'h00
`define WDT_WINDOW_RST 8'h00
`define WDT_STATUS_RST 3'b000
`define WDT_MASK_RST 3'b000
`define WDT_SERVICE_KEY 32'h0000_00a5
`define WDT_PREWARN_TICKS 8'h30
`define WDT_DIV_SLOW 7'h7f
`define WDT_DIV_FAST 7'h01
`define WDT_RESP_OKAY 2'b00
`define WDT_RESP_SLVERR 2'b10

`endif

// ---- rtl/wdt_prescaler.v ----
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.vh"

// Divides the peripheral clock by 2 or by 128 into a one-cycle tick.
module wdt_prescaler (
  // Clock and reset.
  input wire clk_in,
  input wire arst_n_in,
  // Control.
  input wire run_in,
  input wire slow_in,
  input wire clear_in,
  // Tick.
  output reg tick_out
);

  reg [6:0] div;
  wire [6:0] last = slow_in ? `WDT_DIV_SLOW : `WDT_DIV_FAST;

  // Counter restarts on service so the first period after it is whole.
  // While stopped nothing moves, so a pending tick survives a freeze or a suspension.
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div <= 7'h00;
      tick_out <= 1'b0;
    end else if (clear_in) begin
      div <= 7'h00;
      tick_out <= 1'b0;
    end else if (run_in) begin
      tick_out <= (div >= last);
      div <= (div >= last) ? 7'h00 : div + 7'h01;
    end
  end

endmodule
`default_nettype wire

// ---- rtl/wdt_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.vh"

module wdt_top (
  // Clock, reset, enable.
  input wire CLK_IN,
  input wire ARST_N_IN,
  input wire CE_IN,
  // Debug mode pin.
  input wire DEBUG_MODE_IN,
  // AXI4-Lite write address.
  input wire [11:0] AWADDR_IN,
  input wire AWVALID_IN,
  output wire AWREADY_OUT,
  // AXI4-Lite write data.
  input wire [31:0] WDATA_IN,
  input wire [3:0] WSTRB_IN,
  input wire WVALID_IN,
  output wire WREADY_OUT,
  // AXI4-Lite write response.
  output reg [1:0] BRESP_OUT,
  output reg BVALID_OUT,
  input wire BREADY_IN,
  // AXI4-Lite read address.
  input wire [11:0] ARADDR_IN,
  input wire ARVALID_IN,
  output wire ARREADY_OUT,
  // AXI4-Lite read data.
  output reg [31:0] RDATA_OUT,
  output reg [1:0] RRESP_OUT,
  output reg RVALID_OUT,
  input wire RREADY_IN,
  // Watchdog outputs.
  output reg TIMEOUT_NMI_REQUEST_OUT,
  output reg WATCHDOG_SYSTEM_RESET_OUT,
  output wire IRQ_OUT
);

  // -------------------------------------------------------------------------
  // Functions
  // -------------------------------------------------------------------------

  // True when an address selects the given word.
  function hit;
    input [11:0] addr;
    input [11:0] ofs;
    begin
      hit = (addr[11:2] == ofs[11:2]);
    end
  endfunction

  // Byte-lane merge for narrow writes.
  function [7:0] merge8;
    input [7:0] old;
    input [7:0] val;
    input lane;
    begin
      merge8 = lane ? val : old;
    end
  endfunction

  // -------------------------------------------------------------------------
  // Debug pin synchroniser
  // -------------------------------------------------------------------------
  reg dbg_meta;
  reg dbg_sync;

  // The first stage feeds only the second; debug comes from off-domain.
  always @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      dbg_meta <= 1'b0;
      dbg_sync <= 1'b0;
    end else if (CE_IN) begin
      dbg_meta <= DEBUG_MODE_IN;
      dbg_sync <= dbg_meta;
    end
  end

  // -------------------------------------------------------------------------
  // Registers and bus state
  // -------------------------------------------------------------------------
  reg [3:0] ctrl;
  reg [7:0] reload_high_byte;
  reg [7:0] window_boundary_byte;
  reg [`WDT_ST_WIDTH-1:0] status;
  reg [`WDT_ST_WIDTH-1:0] mask;
  reg aw_held;
  reg w_held;
  reg [11:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  wire enable = ctrl[`WDT_CTRL_EN_BIT];
  wire input_prescale_select = ctrl[`WDT_CTRL_PRESCALE_BIT];
  wire win_en = ctrl[`WDT_CTRL_WINEN_BIT];
  wire dbg_run = ctrl[`WDT_CTRL_DBGRUN_BIT];

  // Write completes once both halves are held and no response waits.
  wire wr_go = aw_held && w_held && !BVALID_OUT;
  assign AWREADY_OUT = !aw_held && !BVALID_OUT;
  assign WREADY_OUT = !w_held && !BVALID_OUT;
  assign ARREADY_OUT = !RVALID_OUT;

  wire wr_known = hit(aw_addr, `WDT_CTRL_OFS) || hit(aw_addr, `WDT_RELOAD_OFS) ||
                  hit(aw_addr, `WDT_WINDOW_OFS) || hit(aw_addr, `WDT_SERVICE_OFS) ||
                  hit(aw_addr, `WDT_STATUS_OFS) || hit(aw_addr, `WDT_MASK_OFS);
  wire service = CE_IN && wr_go && hit(aw_addr, `WDT_SERVICE_OFS) && w_strb[0] &&
                 (w_data == `WDT_SERVICE_KEY);

  // -------------------------------------------------------------------------
  // Watchdog core
  // -------------------------------------------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_COUNT = 2'b01;
  localparam ST_PREWARN = 2'b10;
  localparam ST_RESET = 2'b11;

  reg [1:0] state;
  reg [7:0] prewarn_cnt;
  wire [15:0] count;
  wire ovf;
  wire tick;

  // Debug suspends counting unless software lets it run in debug.
  wire run = CE_IN && enable && (!dbg_sync || dbg_run);
  wire counting = run && (state == ST_COUNT);
  wire in_window = (count[15:8] < window_boundary_byte) ||
                   (count == {window_boundary_byte, 8'h00});
  wire bad_service = service && win_en && in_window && (state == ST_COUNT);
  wire good_service = service && !bad_service && (state == ST_COUNT);

  wdt_prescaler u_prescaler (
    .clk_in(CLK_IN),
    .arst_n_in(ARST_N_IN),
    .run_in(run && (state != ST_IDLE) && (state != ST_RESET)),
    .slow_in(input_prescale_select),
    .clear_in(good_service),
    .tick_out(tick)
  );

  wdt_counter u_counter (
    .clk_in(CLK_IN),
    .arst_n_in(ARST_N_IN),
    .tick_in(tick && counting),
    .load_in(good_service || (state == ST_IDLE)),
    .reload_in(state == ST_IDLE ? 8'h00 : reload_high_byte),
    .count_out(count),
    .ovf_out(ovf)
  );

  // State machine: count, prewarning, then a sticky system reset.
  always @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state <= ST_IDLE;
      prewarn_cnt <= 8'h00;
      TIMEOUT_NMI_REQUEST_OUT <= 1'b0;
      WATCHDOG_SYSTEM_RESET_OUT <= 1'b0;
    end else if (CE_IN) begin
      case (state)
        ST_IDLE: begin
          if (enable) begin
            state <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (bad_service) begin
            state <= ST_PREWARN;
            prewarn_cnt <= 8'h00;
          end else if (counting && ovf) begin
            state <= ST_PREWARN;
            prewarn_cnt <= 8'h00;
            TIMEOUT_NMI_REQUEST_OUT <= 1'b1;
          end
        end
        ST_PREWARN: begin
          if (run && tick) begin
            prewarn_cnt <= prewarn_cnt + 8'h01;
            if (prewarn_cnt == `WDT_PREWARN_TICKS - 8'h01) begin
              state <= ST_RESET;
              WATCHDOG_SYSTEM_RESET_OUT <= 1'b1;
            end
          end
        end
        ST_RESET: begin
          // Held until the chip reset clears the block.
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // -------------------------------------------------------------------------
  // Register writes and interrupt status
  // -------------------------------------------------------------------------
  wire [`WDT_ST_WIDTH-1:0] ev;
  assign ev[`WDT_ST_TIMEOUT_BIT] = CE_IN && (state == ST_COUNT) && counting && ovf &&
                                  !bad_service;
  assign ev[`WDT_ST_BADREF_BIT] = bad_service;
  assign ev[`WDT_ST_RESET_BIT] = CE_IN && (state == ST_PREWARN) && run && tick &&
                                (prewarn_cnt == `WDT_PREWARN_TICKS - 8'h01);

  wire st_wr = wr_go && hit(aw_addr, `WDT_STATUS_OFS) && w_strb[0];
  wire [`WDT_ST_WIDTH-1:0] st_clr = st_wr ? w_data[`WDT_ST_WIDTH-1:0] : 3'b000;

  assign IRQ_OUT = |(status & mask);

  // Bus capture, write response and register updates; an event beats its clear.
  always @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      BVALID_OUT <= 1'b0;
      BRESP_OUT <= `WDT_RESP_OKAY;
      ctrl <= `WDT_CTRL_RST;
      reload_high_byte <= `WDT_RELOAD_RST;
      window_boundary_byte <= `WDT_WINDOW_RST;
      status <= `WDT_STATUS_RST;
      mask <= `WDT_MASK_RST;
    end else if (CE_IN) begin
      status <= (status & ~st_clr) | ev;
      if (AWVALID_IN && AWREADY_OUT) begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR_IN;
      end
      if (WVALID_IN && WREADY_OUT) begin
        w_held <= 1'b1;
        w_data <= WDATA_IN;
        w_strb <= WSTRB_IN;
      end
      if (BVALID_OUT && BREADY_IN) begin
        BVALID_OUT <= 1'b0;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        BVALID_OUT <= 1'b1;
        BRESP_OUT <= wr_known ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
        // Enable is sticky once set so software cannot silence the watchdog.
        if (hit(aw_addr, `WDT_CTRL_OFS) && w_strb[0]) begin
          ctrl <= {w_data[3:1], w_data[0] | ctrl[0]};
        end
        if (hit(aw_addr, `WDT_RELOAD_OFS)) begin
          reload_high_byte <= merge8(reload_high_byte, w_data[7:0], w_strb[0]);
        end
        if (hit(aw_addr, `WDT_WINDOW_OFS)) begin
          window_boundary_byte <= merge8(window_boundary_byte, w_data[7:0], w_strb[0]);
        end
        if (hit(aw_addr, `WDT_MASK_OFS) && w_strb[0]) begin
          mask <= w_data[`WDT_ST_WIDTH-1:0];
        end
      end
    end
  end

  // -------------------------------------------------------------------------
  // Read channel
  // -------------------------------------------------------------------------

  // Read data is registered; unmapped words read zero with an error.
  always @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      RVALID_OUT <= 1'b0;
      RDATA_OUT <= 32'h0000_0000;
      RRESP_OUT <= `WDT_RESP_OKAY;
    end else if (CE_IN) begin
      if (RVALID_OUT && RREADY_IN) begin
        RVALID_OUT <= 1'b0;
      end
      if (ARVALID_IN && ARREADY_OUT) begin
        RVALID_OUT <= 1'b1;
        RRESP_OUT <= `WDT_RESP_OKAY;
        if (hit(ARADDR_IN, `WDT_CTRL_OFS)) begin
          RDATA_OUT <= {28'h0000000, ctrl};
        end else if (hit(ARADDR_IN, `WDT_RELOAD_OFS)) begin
          RDATA_OUT <= {24'h000000, reload_high_byte};
        end else if (hit(ARADDR_IN, `WDT_WINDOW_OFS)) begin
          RDATA_OUT <= {24'h000000, window_boundary_byte};
        end else if (hit(ARADDR_IN, `WDT_SERVICE_OFS)) begin
          RDATA_OUT <= 32'h0000_0000;
        end else if (hit(ARADDR_IN, `WDT_COUNT_OFS)) begin
          RDATA_OUT <= {12'h000, 2'b00, state, count};
        end else if (hit(ARADDR_IN, `WDT_STATUS_OFS)) begin
          RDATA_OUT <= {29'h0000000, status};
        end else if (hit(ARADDR_IN, `WDT_MASK_OFS)) begin
          RDATA_OUT <= {29'h0000000, mask};
        end else begin
          RDATA_OUT <= 32'h0000_0000;
          RRESP_OUT <= `WDT_RESP_SLVERR;
        end
      end
    end
  end

endmodule
`default_nettype wire
